// ===== design/sar_adc_defines.vh
// Purpose: constants for the SAR converter sequencer
// Assumes: AXI4-Lite byte address is four times the register index
// Notes: How it works list below
//
// How it works
// [R1] channel select picks input equal to code
// [R2] gate bit disconnects or connects selected input
// [R3] resolution bit: zero 8-bit, one 12-bit
// [R4] clock select divides oscillator 16/8/1/2
// [R5] start needs enable; clearing enable stops
// [R6] completion sets end flag, irq flag, result
// [R7] start bit self-clears when conversion ends
// [R8] end flag low while busy, high after
// [R9] enabled irq flag raises interrupt, vector 15H
// [R10] software clears irq flag, hardware never does
// [R11] runs in green mode, completion wakes system
// [R12] time runs from start to end flag
// [R13] 12-bit takes 64 conversion clocks
// [R14] 8-bit takes 48 conversion clocks
// [R15] bits 11:4 high byte, 3:0 low nibble
// [R16] 8-bit result sits in high byte only
// [R17] result read-only, undefined after reset
// [R18] code is input over reference times 4096
// [R19] channel-0 gating, analog select, pulldown set mode
// [R20] software orders battery measurement enable steps
// [R21] software programs settings before setting start
// [R22] writing start one clears end flag
// [R23] software waits warm-up after enabling converter
// [R24] settings latched at start, held until end
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH

// register indices; byte address is index * 4
`define IDX_MODE 10'h0c8
`define IDX_RESULT_HI 10'h0c9
`define IDX_RATE_RES 10'h0ca
`define IDX_EXT_CTRL 10'h0cc

// converter_mode_ctrl fields
`define MODE_ENABLE 7
`define MODE_START 6
`define MODE_EOC 5
`define MODE_GATE 4
// rate_resolution_low_nibble fields
`define RATE_HVGATE 7
`define RATE_CKS1 6
`define RATE_RES 5
`define RATE_CKS0 4
`define RATE_HVGATE_RST 1'b1
// ext_ctrl fields
`define EXT_IRQ_FLAG 0
`define EXT_IRQ_EN 1
`define EXT_PURE 2
`define EXT_PDN 3

// prescaler terminal counts (divide minus one)
`define CKS_LIM_16 4'h0f
`define CKS_LIM_8 4'h07
`define CKS_LIM_1 4'h00
`define CKS_LIM_2 4'h01

// conversion clock counts: 16 sampling, then 4 per bit
`define LAST_TICK_12 6'h3f
`define LAST_TICK_8 6'h2f
`define PERIOD_END 2'h3
`define SAMPLE_PHASE 2'h0

`define SAR_MID 12'h0800
`define IRQ_VECTOR 8'h15
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== design/conv_clock_prescaler.v
// Purpose: conversion clock tick from the oscillator clock
// Assumes: aclk is the high oscillator
// Notes: clear restarts the period so the first tick is a full one
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_defines.vh"
module conv_clock_prescaler
(
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// control
	input wire clear,
	input wire [1:0] clock_select,
	// tick out
	output wire tick
);
	reg [3:0] cnt_ff;
	reg [3:0] limit;

	always @*
	begin
		case (clock_select) // [R4]
			2'h0: limit = `CKS_LIM_16;
			2'h1: limit = `CKS_LIM_8;
			2'h2: limit = `CKS_LIM_1;
			default: limit = `CKS_LIM_2;
		endcase
	end

	assign tick = (cnt_ff == limit) && !clear;

	always @(posedge aclk)
	begin
		if (!aresetn || clear || tick)
			cnt_ff <= 4'h0;
		else
			cnt_ff <= cnt_ff + 4'h1;
	end
endmodule
`default_nettype wire

// ===== design/sar_bit_search.v
// Purpose: successive approximation trial register
// Assumes: compare_high is one when input >= trial code
// Notes: 8-bit mode stops after bit 4, low nibble stays zero
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_defines.vh"
module sar_bit_search
(
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// control
	input wire init,
	input wire step,
	input wire twelve_bit,
	input wire compare_high,
	// trial code to the dac
	output reg [11:0] code_ff
);
	reg [11:0] bit_ff;
	reg [11:0] nxt_bit;

	always @*
	begin
		nxt_bit = bit_ff >> 1;
		if (!twelve_bit && bit_ff[4]) // [R16]
			nxt_bit = 12'h0000;
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			code_ff <= `SAR_MID;
			bit_ff <= `SAR_MID;
		end
		else if (init)
		begin
			code_ff <= `SAR_MID;
			bit_ff <= `SAR_MID;
		end
		else if (step)
		begin
			// keep the bit if input is at or above the trial [R18]
			code_ff <= (compare_high ? code_ff : (code_ff & ~bit_ff))
				| nxt_bit;
			bit_ff <= nxt_bit;
		end
	end
endmodule
`default_nettype wire

// ===== design/sar_adc_sequencer.v
// Purpose: register file and sequencer for a 16-input SAR converter
// Assumes: AXI4-Lite slave, one write and one read in flight
// Notes: result buffer has no reset and reads unknown until first result
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_defines.vh"
module sar_adc_sequencer
(
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi write address
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi read
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// analog macro
	input wire compare_high,
	output wire [11:0] dac_code,
	output reg [3:0] mux_channel_ff,
	output reg mux_connect_ff,
	output reg converter_power_ff,
	output reg sample_hold_ff,
	output reg hv_detect_ff,
	output reg ch0_pulldown_ff,
	output reg ch0_analog_ff,
	// system
	input wire green_mode,
	output reg irq_ff,
	output reg [7:0] irq_vector_ff,
	output reg wake_req_ff
);
	localparam ST_IDLE = 3'b001;
	localparam ST_RUN = 3'b010;
	localparam ST_DONE = 3'b100;

	// software visible state
	reg converter_enable_ff;
	reg conversion_start_ff;
	reg eoc_ff;
	reg global_channel_gate_ff;
	reg [3:0] channel_select_ff;
	reg ch0_hv_gate_enable_ff;
	reg [1:0] conversion_clock_select_ff;
	reg resolution_select_ff;
	reg [11:0] result_ff;
	reg conversion_irq_flag_ff;
	reg conversion_irq_enable_ff;
	reg ch0_pure_analog_select_ff;
	reg ch0_pulldown_enable_ff;

	// settings held for the conversion in flight
	reg [3:0] lat_channel_ff;
	reg lat_twelve_ff;
	reg [1:0] lat_cks_ff;
	reg [2:0] state_ff;
	reg [5:0] tick_cnt_ff;

	// bus holding state
	reg aw_have_ff;
	reg w_have_ff;
	reg [9:0] waddr_ff;
	reg [7:0] wdata_ff;
	reg wlane_ff;

	wire tick;
	wire start_go;
	wire abort;
	wire finish;
	wire sar_step;
	wire last_tick;
	wire do_write;
	wire wr_mode;
	wire wr_rate;
	wire wr_ext;

	function addr_ok;
		input [9:0] idx;
		begin
			addr_ok = (idx == `IDX_MODE) || (idx == `IDX_RESULT_HI)
				|| (idx == `IDX_RATE_RES) || (idx == `IDX_EXT_CTRL);
		end
	endfunction

	function [7:0] read_reg;
		input [9:0] idx;
		begin
			case (idx)
				`IDX_MODE:
					read_reg = {converter_enable_ff, conversion_start_ff,
						eoc_ff, global_channel_gate_ff,
						channel_select_ff}; // [R8]
				`IDX_RESULT_HI:
					read_reg = result_ff[11:4]; // [R15]
				`IDX_RATE_RES:
					read_reg = {ch0_hv_gate_enable_ff,
						conversion_clock_select_ff[1],
						resolution_select_ff,
						conversion_clock_select_ff[0],
						result_ff[3:0]}; // [R15]
				`IDX_EXT_CTRL:
					read_reg = {4'h0, ch0_pulldown_enable_ff,
						ch0_pure_analog_select_ff,
						conversion_irq_enable_ff,
						conversion_irq_flag_ff};
				default:
					read_reg = 8'h00;
			endcase
		end
	endfunction

	// write channel: address and data taken in either order
	assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;
	assign wr_mode = do_write && wlane_ff && (waddr_ff == `IDX_MODE);
	assign wr_rate = do_write && wlane_ff && (waddr_ff == `IDX_RATE_RES);
	assign wr_ext = do_write && wlane_ff && (waddr_ff == `IDX_EXT_CTRL);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			waddr_ff <= 10'h000;
			wdata_ff <= 8'h00;
			wlane_ff <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_ff <= 1'b1;
				s_axi_awready <= 1'b0;
				waddr_ff <= s_axi_awaddr[11:2];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_ff <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_ff <= s_axi_wdata[7:0];
				wlane_ff <= s_axi_wstrb[0];
			end
			if (do_write)
			begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_ok(waddr_ff) ? `RESP_OKAY
					: `RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read channel: data registered on the same edge that takes the address
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, read_reg(s_axi_araddr[11:2])};
			s_axi_rresp <= addr_ok(s_axi_araddr[11:2]) ? `RESP_OKAY
				: `RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// sequencer
	assign start_go = (state_ff == ST_IDLE) && converter_enable_ff
		&& conversion_start_ff; // [R5]
	assign abort = !converter_enable_ff || !conversion_start_ff; // [R5]
	assign last_tick = tick && (tick_cnt_ff == (lat_twelve_ff ?
		`LAST_TICK_12 : `LAST_TICK_8)); // [R13] [R14]
	// a bit decision closes each four-tick period after sampling
	assign sar_step = (state_ff == ST_RUN) && tick
		&& (tick_cnt_ff[1:0] == `PERIOD_END)
		&& (tick_cnt_ff[5:4] != `SAMPLE_PHASE);
	assign finish = (state_ff == ST_DONE);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= ST_IDLE;
			tick_cnt_ff <= 6'h00;
			lat_channel_ff <= 4'h0;
			lat_twelve_ff <= 1'b0;
			lat_cks_ff <= 2'h0;
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
					if (start_go)
					begin
						state_ff <= ST_RUN;
						tick_cnt_ff <= 6'h00;
						lat_channel_ff <= channel_select_ff; // [R24]
						lat_twelve_ff <= resolution_select_ff; // [R24]
						lat_cks_ff <= conversion_clock_select_ff; // [R24]
					end
				ST_RUN:
					if (abort)
						state_ff <= ST_IDLE;
					else if (last_tick)
						state_ff <= ST_DONE; // [R12]
					else if (tick)
						tick_cnt_ff <= tick_cnt_ff + 6'h01;
				ST_DONE:
					state_ff <= ST_IDLE;
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	// result buffer has no reset on purpose; software only reads it
	always @(posedge aclk)
	begin
		if (finish)
			result_ff <= dac_code; // [R6] [R16] [R17]
	end

	// software registers with hardware side effects
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			converter_enable_ff <= 1'b0;
			conversion_start_ff <= 1'b0;
			eoc_ff <= 1'b0;
			global_channel_gate_ff <= 1'b0;
			channel_select_ff <= 4'h0;
			ch0_hv_gate_enable_ff <= `RATE_HVGATE_RST;
			conversion_clock_select_ff <= 2'h0;
			resolution_select_ff <= 1'b0;
			conversion_irq_flag_ff <= 1'b0;
			conversion_irq_enable_ff <= 1'b0;
			ch0_pure_analog_select_ff <= 1'b0;
			ch0_pulldown_enable_ff <= 1'b0;
		end
		else
		begin
			if (wr_mode)
			begin
				converter_enable_ff <= wdata_ff[`MODE_ENABLE];
				global_channel_gate_ff <= wdata_ff[`MODE_GATE];
				channel_select_ff <= wdata_ff[3:0];
			end
			// a fresh software start beats the completion clear
			if (wr_mode)
				conversion_start_ff <= wdata_ff[`MODE_START];
			else if (finish || !converter_enable_ff)
				conversion_start_ff <= 1'b0; // [R7] [R5]
			// completion wins over a clear in the same cycle
			if (finish)
				eoc_ff <= 1'b1; // [R6] [R8]
			else if (wr_mode && (wdata_ff[`MODE_START]
				|| !wdata_ff[`MODE_EOC]))
				eoc_ff <= 1'b0; // [R22] [R8]
			if (wr_rate)
			begin
				ch0_hv_gate_enable_ff <= wdata_ff[`RATE_HVGATE];
				conversion_clock_select_ff <= {wdata_ff[`RATE_CKS1],
					wdata_ff[`RATE_CKS0]}; // [R4]
				resolution_select_ff <= wdata_ff[`RATE_RES]; // [R3]
			end
			if (finish)
				conversion_irq_flag_ff <= 1'b1; // [R6]
			else if (wr_ext && !wdata_ff[`EXT_IRQ_FLAG])
				conversion_irq_flag_ff <= 1'b0; // [R10]
			if (wr_ext)
			begin
				conversion_irq_enable_ff <= wdata_ff[`EXT_IRQ_EN];
				ch0_pure_analog_select_ff <= wdata_ff[`EXT_PURE];
				ch0_pulldown_enable_ff <= wdata_ff[`EXT_PDN];
			end
		end
	end

	// analog and system outputs, all registered
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mux_channel_ff <= 4'h0;
			mux_connect_ff <= 1'b0;
			converter_power_ff <= 1'b0;
			sample_hold_ff <= 1'b0;
			hv_detect_ff <= 1'b0;
			ch0_pulldown_ff <= 1'b0;
			ch0_analog_ff <= 1'b0;
			irq_ff <= 1'b0;
			irq_vector_ff <= 8'h00;
			wake_req_ff <= 1'b0;
		end
		else
		begin
			mux_channel_ff <= (state_ff == ST_IDLE) ? channel_select_ff
				: lat_channel_ff; // [R1] [R24]
			// input 0 carries nothing while gated in analog mode
			mux_connect_ff <= converter_enable_ff && global_channel_gate_ff
				&& !((mux_channel_ff == 4'h0) && ch0_hv_gate_enable_ff
				&& ch0_pure_analog_select_ff); // [R2] [R19]
			converter_power_ff <= converter_enable_ff; // [R5]
			sample_hold_ff <= (state_ff == ST_RUN) && !abort
				&& (tick_cnt_ff[5:4] == `SAMPLE_PHASE);
			hv_detect_ff <= !ch0_hv_gate_enable_ff
				&& ch0_pure_analog_select_ff
				&& ch0_pulldown_enable_ff; // [R19]
			ch0_pulldown_ff <= ch0_pulldown_enable_ff; // [R19]
			ch0_analog_ff <= ch0_pure_analog_select_ff; // [R19]
			irq_ff <= conversion_irq_flag_ff && conversion_irq_enable_ff; // [R9]
			irq_vector_ff <= (conversion_irq_flag_ff
				&& conversion_irq_enable_ff) ? `IRQ_VECTOR : 8'h00; // [R9]
			wake_req_ff <= finish && green_mode; // [R11]
		end
	end

	conv_clock_prescaler u_prescaler
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(start_go),
		.clock_select(lat_cks_ff),
		.tick(tick)
	);

	sar_bit_search u_sar
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.init(start_go),
		.step(sar_step),
		.twelve_bit(lat_twelve_ff),
		.compare_high(compare_high),
		.code_ff(dac_code)
	);
endmodule
`default_nettype wire

// ===== verif/sar_analog_model.sv
// Purpose: comparator and input mux standing in for the analog macro
// Assumes: one 12-bit level per input, packed input 0 lowest
// Notes: a disconnected or unpowered input always compares low
`timescale 1ns/10ps
`default_nettype none
module sar_analog_model
(
	// levels and trial code
	input wire logic [191:0] levels,
	input wire logic [11:0] dac_code,
	// mux control
	input wire logic [3:0] mux_channel_ff,
	input wire logic mux_connect_ff,
	input wire logic converter_power_ff,
	// comparator out
	output logic compare_high
);
	assign compare_high = mux_connect_ff && converter_power_ff &&
		(levels[mux_channel_ff * 12 +: 12] >= dac_code);
endmodule
`default_nettype wire

// ===== verif/sar_adc_sequencer_asserts.sv
// Purpose: port-level assertions for the converter sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every instance of the sequencer
`timescale 1ns/10ps
`default_nettype none
module sar_adc_checker
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus
	input wire logic s_axi_awready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// analog side
	input wire logic [11:0] dac_code,
	input wire logic [3:0] mux_channel_ff,
	input wire logic mux_connect_ff,
	input wire logic converter_power_ff,
	input wire logic sample_hold_ff,
	input wire logic hv_detect_ff,
	input wire logic ch0_pulldown_ff,
	input wire logic ch0_analog_ff,
	// system
	input wire logic irq_ff,
	input wire logic [7:0] irq_vector_ff,
	input wire logic wake_req_ff
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_sampling;
		sample_hold_ff [*8];
	endsequence
	property p_sample_len;
		$rose(sample_hold_ff) |-> s_sampling;
	endproperty
	a_sample_len: assert property (p_sample_len)
		else $error("sampling phase too short");
	property p_sample_mid;
		sample_hold_ff |-> dac_code == 12'h800;
	endproperty
	a_sample_mid: assert property (p_sample_mid)
		else $error("trial code not midscale while sampling");
	property p_chan_hold;
		sample_hold_ff && $past(sample_hold_ff) |-> $stable(mux_channel_ff);
	endproperty
	a_chan_hold: assert property (p_chan_hold)
		else $error("channel moved during conversion");
	property p_connect;
		mux_connect_ff |-> converter_power_ff;
	endproperty
	a_connect: assert property (p_connect)
		else $error("input connected while converter off");
	property p_hv;
		hv_detect_ff |-> ch0_pulldown_ff && ch0_analog_ff;
	endproperty
	a_hv: assert property (p_hv)
		else $error("battery mode without pulldown and analog select");
	property p_vector;
		irq_vector_ff == (irq_ff ? 8'h15 : 8'h00);
	endproperty
	a_vector: assert property (p_vector)
		else $error("interrupt vector wrong");
	property p_wake;
		wake_req_ff |=> !wake_req_ff;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake request longer than one cycle");
	property p_ar;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_ar: assert property (p_ar)
		else $error("read answer late");
	// the master offers ready with its request, so check the refusal
	// window instead of a wait that never happens
	property p_rhold;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("new read taken while answer pending");
	property p_bhold;
		s_axi_bvalid |-> !s_axi_awready;
	endproperty
	a_bhold: assert property (p_bhold)
		else $error("new write taken while response pending");
endmodule
bind sar_adc_sequencer sar_adc_checker u_chk (.aclk, .aresetn,
	.s_axi_awready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .dac_code,
	.mux_channel_ff, .mux_connect_ff, .converter_power_ff, .sample_hold_ff,
	.hv_detect_ff, .ch0_pulldown_ff, .ch0_analog_ff, .irq_ff,
	.irq_vector_ff, .wake_req_ff);
`default_nettype wire

// ===== verif/tb_sar_adc_sequencer.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: byte address is four times the register index
// Notes: interrupt enabled so irq marks the end of each conversion
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_defines.vh"
module tb_sar_adc_sequencer;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, green, cmp;
	logic conn, pwr, sh, hv, pdn, ana, irq, wake;
	logic [11:0] awaddr, araddr, dac;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, chan;
	logic [1:0] bresp, rresp;
	logic [7:0] vec;
	logic [191:0] levels;
	int n_fail, tests_run, wakes, i;
	// mode, rate, level, green
	logic [28:0] tbl [8] = '{{8'hd0, 8'he0, 12'habc, 1'h0},
		{8'hdf, 8'hf0, 12'hfff, 1'h1}, {8'hd7, 8'h90, 12'h5a7, 1'h0},
		{8'hd3, 8'h80, 12'h001, 1'h1}, {8'hc9, 8'he0, 12'h800, 1'h0},
		{8'hda, 8'hb0, 12'h001, 1'h0}, {8'hdc, 8'ha0, 12'h7ff, 1'h0},
		{8'hd1, 8'hd0, 12'hfff, 1'h0}};
	sar_adc_sequencer dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .compare_high(cmp),
		.dac_code(dac), .mux_channel_ff(chan), .mux_connect_ff(conn),
		.converter_power_ff(pwr), .sample_hold_ff(sh), .hv_detect_ff(hv),
		.ch0_pulldown_ff(pdn), .ch0_analog_ff(ana), .green_mode(green),
		.irq_ff(irq), .irq_vector_ff(vec), .wake_req_ff(wake));
	sar_analog_model u_ana (.levels(levels), .dac_code(dac),
		.mux_channel_ff(chan), .mux_connect_ff(conn),
		.converter_power_ff(pwr), .compare_high(cmp));
	initial
	begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk)
		if (wake === 1'h1) wakes++;
	task automatic conclude;
		$display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'h1)
		begin
			n_fail++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask
	// ready is offered with the request, so the answer is taken on the
	// very edge at which valid is first seen high
	task automatic wr(input logic [9:0] ix, input logic [7:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= {ix, 2'h0};
		wdata <= {24'h00_0000, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [9:0] ix, output logic [7:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= {ix, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata[7:0];
		r = rresp;
		rready <= 1'h0;
	endtask
	task automatic t_reset;
		logic [7:0] d;
		logic [1:0] r;
		rd(`IDX_MODE, d, r);
		chk(d === 8'h00 && r === `RESP_OKAY, "mode reset");
		rd(`IDX_RATE_RES, d, r);
		chk(d[7:4] === 4'h8, "rate reset");
		rd(`IDX_EXT_CTRL, d, r);
		chk(d === 8'h00, "ext reset");
		rd(10'h0d0, d, r);
		chk(d === 8'h00 && r === `RESP_SLVERR, "unmapped read");
		wr(10'h0d0, 8'hff, r);
		chk(r === `RESP_SLVERR, "unmapped write");
		wstrb <= 4'h0;
		wr(`IDX_EXT_CTRL, 8'h0e, r);
		wstrb <= 4'hf;
		rd(`IDX_EXT_CTRL, d, r);
		chk(d === 8'h00 && r === `RESP_OKAY, "masked write landed");
		chk(dac === 12'h800 && pwr === 1'h0, "idle outputs");
		// enable alone first and let the converter warm up before a start
		wr(`IDX_MODE, 8'h80, r);
		repeat (10_000) @(posedge aclk);
		$display("test reset done");
	endtask
	task automatic t_conv(input logic [28:0] e);
		logic [7:0] md, rt, m, hi, lo;
		logic [11:0] lv, x;
		logic [1:0] r;
		int lim, n;
		{md, rt, lv} = e[28:1];
		lim = (rt[5] ? 64 : 48) * (rt[6] ? (rt[4] ? 2 : 1) : (rt[4] ? 8 : 16));
		x = !md[4] ? 12'h000 : rt[5] ? lv : {lv[11:4], 4'h0};
		levels[md[3:0] * 12 +: 12] <= lv;
		green <= e[0];
		wr(`IDX_RATE_RES, rt, r);
		wr(`IDX_EXT_CTRL, 8'h02, r);
		wr(`IDX_MODE, md, r);
		wakes = 0;
		for (n = 0; n < 2000 && irq !== 1'h1; n++)
			@(posedge aclk);
		chk(n >= lim-1 && n <= lim+4, "time");
		rd(`IDX_MODE, m, r);
		chk(m === {3'h5, md[4:0]}, "mode at end");
		rd(`IDX_RESULT_HI, hi, r);
		rd(`IDX_RATE_RES, lo, r);
		chk({hi, lo[3:0]} === x, "result");
		chk(lo[7:4] === rt[7:4], "rate kept");
		chk(irq === 1'h1 && vec === 8'h15, "irq held");
		chk(wakes == e[0], "wake count");
		wr(`IDX_EXT_CTRL, 8'h02, r);
		repeat (2) @(posedge aclk);
		chk(irq === 1'h0, "irq not cleared");
		$display("test conversion %h done", md);
	endtask
	task automatic t_abort;
		logic [7:0] m, h0, h1;
		logic [1:0] r;
		rd(`IDX_RESULT_HI, h0, r);
		wr(`IDX_RESULT_HI, ~h0, r);
		rd(`IDX_RESULT_HI, h1, r);
		chk(h1 === h0, "result written");
		wr(`IDX_RATE_RES, 8'h80, r);
		wr(`IDX_MODE, 8'hd5, r);
		rd(`IDX_MODE, m, r);
		chk(m === 8'hd5, "end flag not cleared by start");
		// stop only once sampling is over, the sampling check wants at least eight cycles of it
		repeat (300) @(posedge aclk);
		wr(`IDX_MODE, 8'h95, r);
		repeat (900) @(posedge aclk);
		rd(`IDX_MODE, m, r);
		chk(m === 8'h95 && irq === 1'h0, "stop did not abort");
		wr(`IDX_MODE, 8'hd5, r);
		repeat (300) @(posedge aclk);
		wr(`IDX_MODE, 8'h55, r);
		repeat (900) @(posedge aclk);
		rd(`IDX_MODE, m, r);
		chk(m[5] === 1'h0 && irq === 1'h0 && pwr === 1'h0, "disable");
		$display("test abort done");
	endtask
	task automatic t_hv;
		logic [1:0] r;
		wr(`IDX_EXT_CTRL, 8'h0a, r);
		wr(`IDX_EXT_CTRL, 8'h0e, r);
		wr(`IDX_RATE_RES, 8'h00, r);
		wr(`IDX_MODE, 8'h90, r);
		repeat (2) @(posedge aclk);
		chk(hv === 1'h1 && conn === 1'h1 && chan === 4'h0, "battery");
		wr(`IDX_RATE_RES, 8'h80, r);
		repeat (2) @(posedge aclk);
		chk(hv === 1'h0 && conn === 1'h0, "input 0 gated");
		wr(`IDX_MODE, 8'h9f, r);
		repeat (2) @(posedge aclk);
		chk(chan === 4'hf && conn === 1'h1, "input 15");
		wr(`IDX_MODE, 8'h8f, r);
		repeat (2) @(posedge aclk);
		chk(conn === 1'h0, "gate off");
		$display("test input 0 modes done");
	endtask
	initial
	begin
		#300_000;
		n_fail++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		conclude();
	end
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, green} = 7'h00;
		{awaddr, araddr, wdata} = 56'h00_0000_0000_0000;
		wstrb = 4'hf;
		levels = 192'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset();
		for (i = 0; i < 8; i++)
			t_conv(tbl[i]);
		t_abort();
		t_hv();
		conclude();
	end
endmodule
`default_nettype wire
